// file: hdl/e1_frame_crc4_alignment.v
/*
 * Primary-rate framer: transmit frame build with checksum insertion,
 * receive frame/multiframe alignment, checksum check and false-alignment
 * detection. Line bits and bit ticks arrive from pins and are resynchronised;
 * ticks must be far slower than sys_clk_i. Payload for slots 1..31 comes
 * through a FIFO from the user.
 */
//
// What this block does
// - Zero checksum positions before computing transmit checksum
// - Insert held remainder into next half multiframe
// - Receive checksum computed with check bits zeroed
// - Store remainder, compare against next block bits
// - Block error free only on exact match
// - Frame is 32 eight-bit slots, slot 0 first
// - Three bad alignment words declare sync lost
// - Multiframe failure or checksum limit also loses sync
// - Optional loss on three bad bit-2 checks
// - Recovery needs pattern, bit two one, pattern
// - Failed confirmation restarts search just after the failing check
// - Two multiframe words, 2 ms spaced, within 8 ms
// - Multiframe search only in non-pattern frames
// - No multiframe in 8 ms restarts search after
// - Withdraw actions on recovery unless multiframe timer already expired; reapply after timeout
// - Checksum monitoring only when fully aligned
// - 915 of 1000 bad blocks means false alignment
// - Alternate frames carry pattern, others bit two one
// - Non-pattern bit one carries 001011 and E bits
// - Checksum is x^4 scaled remainder by x^4+x+1
// - Multiframe splits into two checksum blocks
`timescale 1ns/1ps
`include "e1_framer_defines.vh"
module e1_frame_crc4_alignment #(
    parameter MF_TIMEOUT_MS = `MF_TIMEOUT_MS,
    parameter FIFO_DEPTH    = 32,
    parameter FIFO_AW       = 5
) (
    input  wire       sys_clk_i,
    input  wire       rst_i,
    input  wire       rx_line_i,
    input  wire       rx_bit_tick_i,
    input  wire       tx_bit_tick_i,
    input  wire       tx_rai_i,
    input  wire       bit2_loss_en_i,
    input  wire [7:0] tx_payload_i,
    input  wire       tx_payload_valid_i,
    output wire       tx_payload_ready_o,
    output reg        tx_line_o,
    output reg        frame_aligned_o,
    output reg        mf_aligned_o,
    output reg        frame_sync_lost_o,
    output reg        lof_action_o,
    output reg        crc_error_o
);
    localparam [15:0] MF_SEARCH_FRAMES = `MF_SEARCH_FRAMES;
    localparam [15:0] MF_TIMEOUT_FRAMES = (MF_TIMEOUT_MS * 1000) / `FRAME_PERIOD_US;
    localparam [5:0]  MFAS_BITS         = `MFAS_WORD;

    localparam [1:0] ST_SEARCH   = 2'h0;
    localparam [1:0] ST_CHK_NFAS = 2'h1;
    localparam [1:0] ST_CHK_FAS  = 2'h2;
    localparam [1:0] ST_ALIGNED  = 2'h3;

    // One checksum step, msb first; multiply by x^4 is implicit
    function [3:0] crc4_step;
        input [3:0] crc;
        input       din;
        begin
            crc4_step = {crc[2:0], 1'b0} ^ ((crc[3] ^ din) ? `CRC_POLY_LOW : 4'h0);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; edge found on second and third stages only
    reg [2:0] rx_tick_sync;
    reg [2:0] tx_tick_sync;
    reg [1:0] rx_line_sync;
    wire      rx_tick = rx_tick_sync[1] && !rx_tick_sync[2];
    wire      tx_tick = tx_tick_sync[1] && !tx_tick_sync[2];
    wire      rx_bit  = rx_line_sync[1];

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            rx_tick_sync <= 3'h0;
            tx_tick_sync <= 3'h0;
            rx_line_sync <= 2'h0;
        end else begin
            rx_tick_sync <= {rx_tick_sync[1:0], rx_bit_tick_i};
            tx_tick_sync <= {tx_tick_sync[1:0], tx_bit_tick_i};
            rx_line_sync <= {rx_line_sync[0], rx_line_i};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit
    reg  [7:0] tx_pos;
    reg  [3:0] tx_frame;
    reg  [3:0] tx_crc;
    reg  [3:0] tx_rem;
    reg  [7:0] tx_byte;
    wire [7:0] fifo_data;
    wire       fifo_valid;
    wire [4:0] tx_slot = tx_pos[7:3];
    wire [2:0] tx_bidx = tx_pos[2:0];
    wire       tx_is_c = (tx_pos == 8'h00) && !tx_frame[0];
    wire       fifo_pop = tx_tick && (tx_slot != 5'h00) && (tx_bidx == 3'h0);
    wire [7:0] new_byte = fifo_valid ? fifo_data : `IDLE_BYTE;
    reg        ts0_b1;
    reg  [7:0] ts0_byte;
    reg        next_tx_bit;

    frame_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_tx_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .in_data_i   (tx_payload_i),
        .in_valid_i  (tx_payload_valid_i),
        .in_ready_o  (tx_payload_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop)
    );

    always @* begin
        // Frames 1..11 spell the multiframe word; 13 and 15 carry E bits, idle one
        if (tx_frame[3:1] < 3'h6) begin
            ts0_b1 = MFAS_BITS[3'h5 - tx_frame[3:1]];
        end else begin
            ts0_b1 = 1'b1;
        end
        if (!tx_frame[0]) begin
            ts0_byte = {tx_rem[2'h3 - tx_frame[2:1]], `FAS_WORD};
        end else begin
            ts0_byte = {ts0_b1, 1'b1, tx_rai_i, `SPARE_BITS};
        end
        if (tx_slot == 5'h00) begin
            next_tx_bit = ts0_byte[3'h7 - tx_bidx];
        end else if (tx_bidx == 3'h0) begin
            next_tx_bit = new_byte[7];
        end else begin
            next_tx_bit = tx_byte[3'h7 - tx_bidx];
        end
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            tx_pos    <= 8'h00;
            tx_frame  <= 4'h0;
            tx_crc    <= `CRC_RESET;
            tx_rem    <= `CRC_RESET;
            tx_byte   <= `IDLE_BYTE;
            tx_line_o <= 1'b1;
        end else if (tx_tick) begin
            tx_line_o <= next_tx_bit;
            tx_pos    <= tx_pos + 8'h01;
            if (fifo_pop) begin
                tx_byte <= new_byte;
            end
            if (tx_pos == `FRAME_LAST_POS) begin
                tx_frame <= tx_frame + 4'h1;
            end
            if ((tx_pos == `FRAME_LAST_POS) && (tx_frame[2:0] == `SMF_LAST_FRAME)) begin
                tx_rem <= crc4_step(tx_crc, next_tx_bit);
                tx_crc <= `CRC_RESET;
            end else begin
                tx_crc <= crc4_step(tx_crc, tx_is_c ? 1'b0 : next_tx_bit);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive alignment
    reg  [1:0]  state;
    reg  [7:0]  rx_sh;
    reg  [7:0]  rx_pos;
    reg  [3:0]  rx_frame;
    reg  [1:0]  fas_err;
    reg  [1:0]  bit2_err;
    reg  [5:0]  mfas_sh;
    reg         mfas_seen;
    reg  [15:0] mf_search_cnt;
    reg  [15:0] mf_timeout_cnt;
    reg         ignore_valid;
    reg  [3:0]  rx_crc;
    reg  [3:0]  rx_prev;
    reg         prev_valid;
    reg  [3:0]  rx_cbits;
    reg         crc_active;
    reg  [9:0]  blk_cnt;
    reg  [9:0]  bad_cnt;
    wire [7:0]  sh_next  = {rx_sh[6:0], rx_bit};
    wire        fas_ok   = (sh_next[6:0] == `FAS_WORD);
    wire        at_ts0   = (rx_pos == `TS0_LAST_POS);
    wire        at_wrap  = (rx_pos == `FRAME_LAST_POS);
    wire        smf_end  = at_wrap && (rx_frame[2:0] == `SMF_LAST_FRAME);
    wire        rx_is_c  = (rx_pos == 8'h00) && !rx_frame[0];
    wire [3:0]  crc_fin  = crc4_step(rx_crc, rx_is_c ? 1'b0 : rx_bit);
    wire        blk_bad  = (rx_prev != rx_cbits);
    wire [5:0]  mfas_nxt = {mfas_sh[4:0], sh_next[7]};

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            state             <= ST_SEARCH;
            rx_sh             <= 8'h00;
            rx_pos            <= 8'h00;
            rx_frame          <= 4'h0;
            fas_err           <= 2'h0;
            bit2_err          <= 2'h0;
            mfas_sh           <= 6'h00;
            mfas_seen         <= 1'b0;
            mf_search_cnt     <= 16'h0000;
            mf_timeout_cnt    <= 16'h0000;
            ignore_valid      <= 1'b0;
            rx_crc            <= `CRC_RESET;
            rx_prev           <= `CRC_RESET;
            prev_valid        <= 1'b0;
            rx_cbits          <= 4'h0;
            crc_active        <= 1'b0;
            blk_cnt           <= 10'h000;
            bad_cnt           <= 10'h000;
            frame_aligned_o   <= 1'b0;
            mf_aligned_o      <= 1'b0;
            frame_sync_lost_o <= 1'b1;
            lof_action_o      <= 1'b1;
            crc_error_o       <= 1'b0;
        end else begin
            crc_error_o       <= 1'b0;
            frame_aligned_o   <= (state == ST_ALIGNED);
            frame_sync_lost_o <= (state != ST_ALIGNED);
            // Actions lift on recovery unless the timer, cleared only by multiframe alignment, has run out; return when it does
            lof_action_o      <= (state != ST_ALIGNED) || (!mf_aligned_o &&
                                 (mf_timeout_cnt >= MF_TIMEOUT_FRAMES));
            if (rx_tick) begin
                rx_sh  <= sh_next;
                rx_pos <= rx_pos + 8'h01;
                if (at_wrap) begin
                    rx_frame <= rx_frame + 4'h1;
                    if (!mf_aligned_o && (mf_timeout_cnt < MF_TIMEOUT_FRAMES)) begin
                        mf_timeout_cnt <= mf_timeout_cnt + 16'h0001;
                    end
                end
                case (state)
                    ST_SEARCH: begin
                        // Skip the old spurious position so we slide past it
                        if (fas_ok && !(ignore_valid && at_ts0)) begin
                            state    <= ST_CHK_NFAS;
                            rx_pos   <= `TS0_LAST_POS + 8'h01;
                            rx_frame <= 4'h0;
                        end
                    end
                    ST_CHK_NFAS: begin
                        if (at_ts0) begin
                            state <= sh_next[6] ? ST_CHK_FAS : ST_SEARCH;
                        end
                    end
                    ST_CHK_FAS: begin
                        if (at_ts0) begin
                            if (fas_ok) begin
                                state         <= ST_ALIGNED;
                                ignore_valid  <= 1'b0;
                                fas_err       <= 2'h0;
                                bit2_err      <= 2'h0;
                                mfas_seen     <= 1'b0;
                                mf_search_cnt <= 16'h0000;
                            end else begin
                                state <= ST_SEARCH;
                            end
                        end
                    end
                    ST_ALIGNED: begin
                        if (at_wrap && !mf_aligned_o) begin
                            mf_search_cnt <= mf_search_cnt + 16'h0001;
                            if (mf_search_cnt + 16'h0001 >= MF_SEARCH_FRAMES) begin
                                state        <= ST_SEARCH;
                                ignore_valid <= 1'b1;
                            end
                        end
                        if (at_ts0 && !rx_frame[0]) begin
                            if (fas_ok) begin
                                fas_err <= 2'h0;
                            end else if (fas_err == `FAS_LOSS_COUNT - 2'h1) begin
                                state <= ST_SEARCH;
                            end else begin
                                fas_err <= fas_err + 2'h1;
                            end
                        end
                        if (at_ts0 && rx_frame[0]) begin
                            if (sh_next[6]) begin
                                bit2_err <= 2'h0;
                            end else if (bit2_err == `FAS_LOSS_COUNT - 2'h1) begin
                                if (bit2_loss_en_i) begin
                                    state <= ST_SEARCH;
                                end
                            end else begin
                                bit2_err <= bit2_err + 2'h1;
                            end
                            mfas_sh <= mfas_nxt;
                            // Same phase again means a 2 ms multiple apart
                            if (!mf_aligned_o && (mfas_nxt == `MFAS_WORD)) begin
                                if (mfas_seen && (rx_frame == `MFAS_END_FRAME)) begin
                                    mf_aligned_o <= 1'b1;
                                end
                                mfas_seen <= 1'b1;
                                rx_frame  <= `MFAS_END_FRAME;
                            end
                        end
                    end
                    default: begin
                        state <= ST_SEARCH;
                    end
                endcase

                // Checksum monitor starts at the first block edge when aligned
                if (!crc_active) begin
                    if (smf_end && mf_aligned_o && (state == ST_ALIGNED)) begin
                        crc_active <= 1'b1;
                        rx_crc     <= `CRC_RESET;
                        prev_valid <= 1'b0;
                        blk_cnt    <= 10'h000;
                        bad_cnt    <= 10'h000;
                    end
                end else if (smf_end) begin
                    rx_prev    <= crc_fin;
                    rx_crc     <= `CRC_RESET;
                    prev_valid <= 1'b1;
                    if (prev_valid) begin
                        crc_error_o <= blk_bad;
                        if (blk_bad && (bad_cnt + 10'h001 >= `CRC_FALSE_LIMIT)) begin
                            state        <= ST_SEARCH;
                            ignore_valid <= 1'b1;
                        end
                        if (blk_cnt == `CRC_WINDOW - 10'h001) begin
                            blk_cnt <= 10'h000;
                            bad_cnt <= 10'h000;
                        end else begin
                            blk_cnt <= blk_cnt + 10'h001;
                            bad_cnt <= bad_cnt + {9'h000, blk_bad};
                        end
                    end
                end else begin
                    rx_crc <= crc_fin;
                    if (rx_is_c) begin
                        rx_cbits <= {rx_cbits[2:0], rx_bit};
                    end
                end
            end

            // Leaving alignment drops multiframe alignment and the checksum monitor
            if (state != ST_ALIGNED) begin
                mf_aligned_o <= 1'b0;
                crc_active   <= 1'b0;
            end
            if (mf_aligned_o) begin
                mf_timeout_cnt <= 16'h0000;
            end
        end
    end
endmodule // e1_frame_crc4_alignment

// file: hdl/e1_framer_defines.vh
/*
 * Constants of the primary-rate framer: frame layout, alignment words,
 * checksum polynomial and the alignment timing figures.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef E1_FRAMER_DEFINES_VH
`define E1_FRAMER_DEFINES_VH

// Frame layout
`define FRAME_BITS        256
`define BIT_POS_W         8
`define TS0_LAST_POS      8'h07
`define FRAME_LAST_POS    8'hFF
`define MF_FRAMES         16
`define SMF_LAST_FRAME    3'h7

// Time slot 0 words and the idle payload byte
`define FAS_WORD          7'h1B
`define MFAS_WORD         6'h0B
`define SPARE_BITS        5'h1F
`define IDLE_BYTE         8'hFF

// Checksum x^4 + x + 1, low terms only
`define CRC_POLY_LOW      4'h3
`define CRC_RESET         4'h0

// Alignment thresholds
`define FAS_LOSS_COUNT    2'h3
`define MFAS_END_FRAME    4'hB
`define CRC_WINDOW        10'd1000
`define CRC_FALSE_LIMIT   10'd915

// Timing, in own units, then in frames
`define FRAME_PERIOD_US   125
`define MF_SEARCH_MS      8
`define MF_SEARCH_FRAMES  ((`MF_SEARCH_MS * 1000) / `FRAME_PERIOD_US)
`define MF_TIMEOUT_MS     250

`endif

// file: hdl/frame_fifo.v
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Read data come from an output register; in_ready is registered.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module frame_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             sys_clk_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output reg              in_ready_o,
    output reg  [WIDTH-1:0] out_data_o,
    output reg              out_valid_o,
    input  wire             out_ready_i
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push = in_valid_i && in_ready_o;
    wire            pop  = (count != {(AW+1){1'b0}}) && (!out_valid_o || out_ready_i);
    wire [AW:0]     next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    always @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
        if (rst_i) begin
            wr_ptr      <= {AW{1'b0}};
            rd_ptr      <= {AW{1'b0}};
            count       <= {(AW+1){1'b0}};
            in_ready_o  <= 1'b0;
            out_valid_o <= 1'b0;
            out_data_o  <= {WIDTH{1'b0}};
        end else begin
            count      <= next_count;
            in_ready_o <= (next_count < DEPTH);
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                out_data_o  <= mem[rd_ptr];
                out_valid_o <= 1'b1;
                rd_ptr      <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
        end
    end
endmodule // frame_fifo

// file: verification/e1_frame_crc4_alignment_tb.sv
/* Bench: payload fill, transmit frames, receive alignment, block faults, loss.
   Assumes the peer model drives the receive pins. */
`timescale 1ns/1ps
module e1_frame_crc4_alignment_tb;
    localparam [7:0] mf_word = 8'hF4;
    reg        sys_clk = 1'b0, rst = 1'b1, run = 1'b0, tx_run = 1'b0, tx_tick = 1'b0;
    reg        fas_bad = 1'b0, crc_bad = 1'b0, pay_valid = 1'b0;
    reg  [7:0] pay     = 8'h00;
    reg  [2:0] tph     = 3'h0;
    reg        txb [0:4095];
    wire       rx_line, rx_tick, pay_ready, tx_line, aligned, mf_al, lost, frame_sync_lost, crc_err;
    wire [7:0] fno;
    integer    bad_count = 0, check_count = 0, errs = 0, acc = 0, txi = 0, k;

    e1_frame_crc4_alignment #(.MF_TIMEOUT_MS(1)) dut_u (
        .sys_clk_i(sys_clk), .rst_i(rst), .rx_line_i(rx_line), .rx_bit_tick_i(rx_tick),
        .tx_bit_tick_i(tx_tick), .tx_rai_i(1'b1), .bit2_loss_en_i(1'b0),
        .tx_payload_i(pay), .tx_payload_valid_i(pay_valid), .tx_payload_ready_o(pay_ready),
        .tx_line_o(tx_line), .frame_aligned_o(aligned), .mf_aligned_o(mf_al),
        .frame_sync_lost_o(lost), .lof_action_o(frame_sync_lost), .crc_error_o(crc_err));
    e1_peer_framer peer_u (
        .sys_clk_i(sys_clk), .run_i(run), .fas_bad_i(fas_bad), .crc_bad_i(crc_bad),
        .line_o(rx_line), .tick_o(rx_tick), .frame_no_o(fno));
////////////////////////////////////////////////////////////////////////////////
    always #4 sys_clk = ~sys_clk;
    always @(negedge sys_clk) begin
        if (tx_run) begin
            tph     <= tph + 3'h1;
            tx_tick <= (tph < 3'h4);
        end
    end
    // A bit is taken one tick late, once the line has settled
    always @(posedge tx_tick) begin
        if (txi > 0 && txi <= 4096)
            txb[txi-1] = tx_line;
        txi = txi + 1;
    end
    always @(negedge sys_clk)
        if (crc_err === 1'b1)
            errs = errs + 1;
////////////////////////////////////////////////////////////////////////////////
    task chk(input [7:0] got, input [7:0] exp, input string what);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("Error at %0t: %0s got %h expected %h", $time, what, got, exp);
            end
        end
    endtask
    task at_frame(input [7:0] n);
        while (fno !== n) @(negedge sys_clk);
    endtask
    task check_tx;
        reg [3:0] r;
        reg [7:0] by, e;
        reg       b, fb;
        integer   fr, i, n;
        begin
            r = 4'h0;
            for (fr = 0; fr < 16; fr = fr + 1) begin
                for (i = 0; i < 256; i = i + 1) begin
                    b  = txb[fr*256+i];
                    by = {by[6:0], b};
                    fb = ((i == 0 && !fr[0]) ? 1'b0 : b) ^ r[3];
                    if (fr < 8)
                        r = {r[2:0], 1'b0} ^ {2'b00, fb, fb};
                    n = fr*31 + i/8 - 1;
                    if (i % 8 == 7) begin
                        if (i > 8)
                            e = (n < acc) ? n[7:0] : 8'hFF;
                        else if (fr[0])
                            e = {mf_word[fr[3:1]], 7'h7F};
                        else
                            e = {(fr < 8) ? 1'b0 : r[3 - fr[2:1]], 7'h1B};
                        chk(by, e, "tx byte");
                    end
                end
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", check_count, bad_count);
            if (bad_count == 0 && check_count > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
////////////////////////////////////////////////////////////////////////////////
    initial begin
        #800000;
        bad_count = bad_count + 1;
        $display("Error at %0t: watchdog expired", $time);
        finish_test;
    end
    initial begin
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        chk({2'b00, lost, frame_sync_lost, aligned, mf_al, crc_err, tx_line}, 8'h31, "reset");
        run <= 1'b1;
        @(negedge sys_clk);
        // Fill before transmit starts, so the refusal point is exact
        for (k = 0; k < 40; k = k + 1) begin
            pay       = acc[7:0];
            pay_valid = 1'b1;
            if (pay_ready === 1'b1)
                acc = acc + 1;
            @(negedge sys_clk);
        end
        pay_valid = 1'b0;
        chk(acc[7:0], 8'h21, "fifo fill");
        tx_run <= 1'b1;
        at_frame(8'h04);
        chk({lost, aligned, frame_sync_lost}, 8'h02, "recovered");
        at_frame(8'h14);
        chk({aligned, mf_al, frame_sync_lost}, 8'h05, "mf absent");
        at_frame(8'h1E);
        chk({aligned, mf_al, frame_sync_lost}, 8'h06, "mf found");
        check_tx;
        at_frame(8'h21);
        crc_bad = 1'b1;
        at_frame(8'h22);
        crc_bad = 1'b0;
        at_frame(8'h31);
        chk(errs[7:0], 8'h01, "bad block");
        at_frame(8'h37);
        fas_bad = 1'b1;
        at_frame(8'h3B);
        chk({lost, aligned}, 8'h01, "two bad words");
        at_frame(8'h3D);
        chk({lost, aligned, mf_al, frame_sync_lost}, 8'h09, "sync lost");
        chk(errs[7:0], 8'h01, "clean block");
        finish_test;
    end
endmodule // e1_frame_crc4_alignment_tb

// file: verification/e1_framer_monitor.sv
/* Port checker for the primary-rate framer.
   Assumes one clock, a synchronous active-high reset and the bind below. */
`timescale 1ns/1ps
module e1_framer_monitor (
    input wire sys_clk_i,
    input wire rst_i,
    input wire rx_bit_tick_i,
    input wire tx_bit_tick_i,
    input wire tx_line_o,
    input wire frame_aligned_o,
    input wire mf_aligned_o,
    input wire frame_sync_lost_o,
    input wire lof_action_o,
    input wire crc_error_o
);
    reg        tick_q;
    reg [9:0]  lost_ticks;
    reg [11:0] err_ticks;
    wire       rx_rise = rx_bit_tick_i & ~tick_q;
////////////////////////////////////////////////////////////////////////////////
    // Pin ticks are counted, so the bounds keep a few bits of slack
    always @(posedge sys_clk_i) begin
        tick_q <= rx_bit_tick_i;
        if (rst_i) begin
            lost_ticks <= 10'h000;
            err_ticks  <= 12'hFFF;
        end else begin
            if (!frame_sync_lost_o)
                lost_ticks <= 10'h000;
            else if (rx_rise && lost_ticks != 10'h3FF)
                lost_ticks <= lost_ticks + 10'h001;
            if (crc_error_o)
                err_ticks <= 12'h000;
            else if (rx_rise && err_ticks != 12'hFFF)
                err_ticks <= err_ticks + 12'h001;
        end
    end
////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_crc_one_cycle: assert property (crc_error_o |=> !crc_error_o)
        else $error("crc error pulse too long");
    a_crc_when_aligned: assert property (crc_error_o |-> $past(mf_aligned_o))
        else $error("crc error while not multiframe aligned");
    a_crc_block_gap: assert property (crc_error_o |-> err_ticks >= 12'h7F8)
        else $error("crc errors closer than one block");
    a_lost_inverse: assert property (frame_sync_lost_o != frame_aligned_o)
        else $error("sync lost and aligned disagree");
    a_mf_in_frame: assert property (mf_aligned_o |-> frame_aligned_o)
        else $error("multiframe aligned without frame alignment");
    a_lof_on_loss: assert property (frame_sync_lost_o |-> lof_action_o)
        else $error("no action while sync lost");
    a_lof_mf_clear: assert property (mf_aligned_o && $past(mf_aligned_o) |-> !lof_action_o)
        else $error("action kept while fully aligned");
    a_align_min_time: assert property ($rose(frame_aligned_o) |-> lost_ticks >= 10'h200)
        else $error("alignment recovered in under two frames");
    a_tx_paced: assert property ($changed(tx_line_o) |-> $past(tx_bit_tick_i, 3))
        else $error("transmit bit changed without a tick");
endmodule // e1_framer_monitor

bind e1_frame_crc4_alignment e1_framer_monitor mon_u (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .rx_bit_tick_i(rx_bit_tick_i),
    .tx_bit_tick_i(tx_bit_tick_i), .tx_line_o(tx_line_o), .frame_aligned_o(frame_aligned_o),
    .mf_aligned_o(mf_aligned_o), .frame_sync_lost_o(frame_sync_lost_o),
    .lof_action_o(lof_action_o), .crc_error_o(crc_error_o));

// file: verification/e1_peer_framer.sv
/* Far-end framer model: framed, checksummed traffic and its bit clock.
   Assumes the bench clock and the run and fault controls of the bench. */
`timescale 1ns/1ps
module e1_peer_framer (
    input  wire       sys_clk_i,
    input  wire       run_i,
    input  wire       fas_bad_i,
    input  wire       crc_bad_i,
    output reg        line_o     = 1'b1,
    output reg        tick_o     = 1'b0,
    output reg  [7:0] frame_no_o = 8'h00
);
    localparam [7:0] mf_word = 8'hF4;
    reg [2:0] phase  = 3'h0;
    reg [7:0] bit_no = 8'h00;
    reg [3:0] crc    = 4'h0;
    reg [3:0] held   = 4'h0;
    reg [7:0] ts0;
    reg [3:0] f;
    reg       d;
    reg       fb;
////////////////////////////////////////////////////////////////////////////////
    // 3 high, 3 low: the fastest tick the receiver takes
    always @(negedge sys_clk_i) begin
        if (run_i) begin
            phase = (phase == 3'h5) ? 3'h0 : phase + 3'h1;
            tick_o <= (phase < 3'h3);
            if (phase == 3'h4) begin
                f = frame_no_o[3:0];
                if (!f[0])
                    ts0 = {held[3 - f[2:1]], 7'h1B ^ {6'h00, fas_bad_i}};
                else
                    ts0 = {mf_word[f[3:1]], 7'h5F};
                d = (bit_no < 8'h08) ? ts0[3'h7 - bit_no[2:0]] : (bit_no[1] ^ bit_no[4] ^ f[1]);
                fb = ((bit_no == 8'h00 && !f[0]) ? 1'b0 : d) ^ crc[3];
                crc = {crc[2:0], 1'b0} ^ {2'b00, fb, fb};
                // Fault on the wire only, so the sent check bits stay those of clean data
                line_o <= d ^ (crc_bad_i && bit_no == 8'h09);
                bit_no = bit_no + 8'h01;
                if (bit_no == 8'h00) begin
                    frame_no_o <= frame_no_o + 8'h01;
                    if (f[2:0] == 3'h7) begin
                        held = crc;
                        crc  = 4'h0;
                    end
                end
            end
        end
    end
endmodule // e1_peer_framer
